// ---- hw/logic_slice_group.sv ----
// Group of four logic slices: lookup, ripple arithmetic, RAM and ROM
`timescale 1ns/1ns
// Functional notes
// - Slices 0-2 offer logic, ripple, RAM, ROM; slice 3 never RAM.
// - Each lookup table gives any four-input function from a 16-entry table.
// - The two tables of a slice merge by a select into five inputs.
// - Ripple: 2-bit add, subtract, and add-or-subtract by dynamic control.
// - Ripple: 2-bit up, down and directed counters with asynchronous clear.
// - Ripple: 2-bit directed counter with synchronous preload.
// - Ripple: 2-bit compare gives A>=B, A!=B or A<=B.
// - Ripple: directed counter combined with >= or <= compare.
// - Multiplier cells form Ai*Bj+1 + Ai+1*Bj, two per slice.
// - Serial divider step on 2-bit mantissa, one bit per clock.
// - Serial 2-bit multiplier shifts one or two bits per clock.
// - Fast carry mode gives generate and propagate per slice.
// - RAM mode: 16x4 memory, slices 0 and 1 hold 16x2 each.
// - RAM mode: slice 2 supplies write address and control only.
// - Memory contents are loadable during configuration before use.
// - All four slices serve as ROM with preloaded tables.
// - Lookup outputs feed two registers, or registers load fabric inputs.
// - Registers have sync or async set/reset, clock enable, clock select.
// - Registers capture on rising or falling slice clock edge.
module logic_slice_group
  import slice_group_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Configuration and table preload
  input wire logic cfg_load,
  input wire logic [2:0] cfg_lut,
  input wire logic [LUT_BITS-1:0] cfg_table,
  input wire logic [NUM_SLICES-1:0][1:0] cfg_mode,
  input wire logic [NUM_SLICES-1:0][3:0] cfg_op,
  input wire logic [NUM_SLICES-1:0] cfg_lut5,
  input wire logic [NUM_SLICES-1:0] cfg_direct,
  input wire logic [NUM_SLICES-1:0] cfg_fast_carry,
  input wire logic [NUM_SLICES-1:0] cfg_mul2,
  input wire logic [NUM_SLICES-1:0] cfg_neg_edge,
  input wire logic [NUM_PAIRS-1:0] cfg_clk_sel,
  input wire logic [NUM_PAIRS-1:0] cfg_lsr_async,
  input wire logic [NUM_PAIRS-1:0] cfg_lsr_set,
  input wire logic cfg_ram_en,
  input wire logic cfg_ram_pdp,
  // Fabric data inputs
  input wire logic [NUM_SLICES-1:0][1:0][LUT_IN-1:0] lut_in,
  input wire logic [NUM_SLICES-1:0][1:0] m_in,
  input wire logic [NUM_SLICES-1:0] sel_in,
  input wire logic carry_chain_in,
  // Register control, shared by slice pairs
  input wire logic [NUM_PAIRS-1:0] ce,
  input wire logic [NUM_PAIRS-1:0] local_set_reset,
  input wire logic [NUM_PAIRS-1:0] slice_clk,
  // Fabric outputs
  output logic [NUM_SLICES-1:0][1:0] f_out,
  output logic [NUM_SLICES-1:0][1:0] q_out,
  output logic [NUM_SLICES-1:0] carry_gen,
  output logic [NUM_SLICES-1:0] carry_prop,
  output logic carry_chain_out
);

  typedef struct packed {
    logic [NUM_LUTS-1:0][LUT_BITS-1:0] lut;
    logic [NUM_SLICES-1:0][1:0] q;
    logic [NUM_SLICES-1:0][1:0] f;
    logic [NUM_SLICES-1:0] gen;
    logic [NUM_SLICES-1:0] prop;
    logic cout;
  } group_state_t;

  typedef struct packed {
    logic [1:0] f;
    logic [1:0] qn;
    logic co;
  } ripple_res_t;

  group_state_t st;
  group_state_t next_st;
  logic [NUM_SLICES-1:0][1:0] lut_f;
  logic [NUM_SLICES-1:0][1:0][LUT_IN-1:0] rd_in;
  logic [NUM_PAIRS-1:0] clk_rise;
  logic [NUM_PAIRS-1:0] clk_fall;
  logic [NUM_SLICES-1:0] tick;
  logic [LUT_IN-1:0] waddr;
  logic ram_we;

  // Directed count step; bit 2 is the carry or borrow out
  function automatic logic [2:0] count_step(
    input logic [1:0] q,
    input logic up,
    input logic step
  );
    logic [2:0] r;
    if (up) begin
      r = {1'b0, q} + {2'b00, step};
    end else begin
      r = {1'b0, q} - {2'b00, step};
    end
    return r;
  endfunction : count_step

  // One slice of ripple arithmetic; x holds c0, d0, c1, d1
  function automatic ripple_res_t ripple_step(
    input logic [3:0] op,
    input logic [1:0] a,
    input logic [1:0] b,
    input logic [1:0] q,
    input logic [3:0] x,
    input logic cin,
    input logic mul2
  );
    ripple_res_t r;
    logic [2:0] s;
    logic [2:0] ud;
    logic [3:0] t;
    logic [1:0] m;
    logic eq;
    r = '0;
    r.qn = q;
    s = 3'h0;
    t = 4'h0;
    m = 2'h0;
    eq = a == b;
    ud = count_step(q, x[0], cin);
    case (op)
      OP_ADD: begin
        s = {1'b0, a} + {1'b0, b} + {2'b00, cin};
      end
      OP_SUB: begin
        s = {1'b0, a} + {1'b0, ~b} + {2'b00, cin};
      end
      OP_ADDSUB: begin
        if (x[0]) begin
          s = {1'b0, a} + {1'b0, b} + {2'b00, cin};
        end else begin
          s = {1'b0, a} + {1'b0, ~b} + {2'b00, cin};
        end
      end
      OP_CNT_UP: begin
        s = count_step(q, 1'b1, cin);
      end
      OP_CNT_DN: begin
        s = count_step(q, 1'b0, cin);
      end
      OP_CNT_UD: begin
        s = ud;
      end
      OP_CNT_LOAD: begin
        s = x[1] ? {1'b0, b} : ud;
      end
      OP_CMP: begin
        // Chained form lets wider compares ripple through slices
        if (x[0]) begin
          r.f[0] = a <= b;
          r.co = (a < b) | (eq & cin);
        end else begin
          r.f[0] = a >= b;
          r.co = (a > b) | (eq & cin);
        end
        r.f[1] = !eq;
      end
      OP_CNT_GE: begin
        s = ud;
        r.f[0] = q >= b;
        r.f[1] = q != b;
      end
      OP_CNT_LE: begin
        s = ud;
        r.f[0] = q <= b;
        r.f[1] = q != b;
      end
      OP_MULT_CELL: begin
        m = {1'b0, a[0] & b[1]} + {1'b0, a[1] & b[0]} + {1'b0, cin};
        r.f[0] = m[0];
        m = {1'b0, x[0] & x[3]} + {1'b0, x[2] & x[1]} + {1'b0, m[1]};
        r.f[1] = m[0];
        r.co = m[1];
      end
      OP_SER_DIV: begin
        // Remainder stays below the divisor, so it fits in two bits
        s = {q, x[0]};
        r.f[0] = s >= {1'b0, b};
        if (r.f[0]) begin
          s = s - {1'b0, b};
        end
        r.co = q[1];
      end
      OP_SER_MUL: begin
        t = {2'b00, q} + (x[0] ? {2'b00, a} : 4'h0);
        if (mul2) begin
          t = t + (x[2] ? {1'b0, a, 1'b0} : 4'h0);
          r.f = t[1:0];
          r.qn = t[3:2];
        end else begin
          r.f[0] = t[0];
          r.qn = t[2:1];
        end
      end
      default: begin
        r.qn = q;
      end
    endcase
    if (op <= OP_ADDSUB) begin
      r.f = s[1:0];
      r.qn = s[1:0];
      r.co = s[2];
    end else if (op <= OP_CNT_LOAD || op == OP_CNT_GE || op == OP_CNT_LE) begin
      r.qn = s[1:0];
      r.co = s[2];
      if (op <= OP_CNT_LOAD) begin
        r.f = q;
      end
    end else if (op == OP_SER_DIV) begin
      r.qn = s[1:0];
    end
    return r;
  endfunction : ripple_step

  // Slice clock pins come from fabric, outside this clock domain
  for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair
    edge_sync u_sync (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .pin(slice_clk[p]),
      .rise(clk_rise[p]),
      .fall(clk_fall[p])
    );
  end

  // Slice 2 lookup inputs carry the write address in RAM mode
  assign waddr = lut_in[RAM_CTRL_SLICE][0];

  for (genvar s = 0; s < NUM_SLICES; s++) begin : g_slice
    localparam int P = s / 2;
    // Pair clock select, then per-slice edge choice
    assign tick[s] = cfg_clk_sel[P] ?
      (cfg_neg_edge[s] ? clk_fall[P] : clk_rise[P]) : 1'b1;
    for (genvar k = 0; k < 2; k++) begin : g_rd
      // Single port reads where it writes; pseudo dual reads own inputs
      assign rd_in[s][k] = (cfg_ram_en && s < RAM_STORE_SLICES && !cfg_ram_pdp) ?
        waddr : lut_in[s][k];
    end
    lut_pair u_lut (
      .table0(st.lut[2*s]),
      .table1(st.lut[2*s+1]),
      .in0(rd_in[s][0]),
      .in1(rd_in[s][1]),
      .sel(sel_in[s]),
      .lut5_en(cfg_lut5[s] && !(cfg_ram_en && s < RAM_STORE_SLICES)),
      .f0(lut_f[s][0]),
      .f1(lut_f[s][1])
    );
  end

  // Write strobe comes from slice 2's control pair and clock
  assign ram_we = cfg_ram_en & m_in[RAM_CTRL_SLICE][0] &
    ce[RAM_CTRL_SLICE/2] & tick[RAM_CTRL_SLICE];

  always_comb begin
    ripple_res_t r;
    logic carry;
    logic ram_slice;
    logic ripple;
    logic sub;
    logic [1:0] a;
    logic [1:0] b;
    logic [1:0] bb;
    logic [2:0] gsum;
    logic [1:0] dq;
    logic [1:0] setval;
    logic [3:0] x;
    int p;
    next_st = st;
    carry = carry_chain_in;
    r = '0;
    ram_slice = 1'h0;
    ripple = 1'h0;
    sub = 1'h0;
    a = 2'h0;
    b = 2'h0;
    bb = 2'h0;
    gsum = 3'h0;
    dq = 2'h0;
    setval = 2'h0;
    x = 4'h0;
    p = 0;
    for (int s = 0; s < NUM_SLICES; s++) begin
      p = s / 2;
      // Only slices 0-2 join the memory; slice 3 stays free
      ram_slice = cfg_ram_en && s <= RAM_CTRL_SLICE;
      ripple = !ram_slice && cfg_mode[s] == MODE_RIPPLE;
      a = {lut_in[s][1][IN_A], lut_in[s][0][IN_A]};
      b = {lut_in[s][1][IN_B], lut_in[s][0][IN_B]};
      x = {lut_in[s][1][IN_D], lut_in[s][1][IN_C],
           lut_in[s][0][IN_D], lut_in[s][0][IN_C]};
      r = ripple_step(cfg_op[s], a, b, st.q[s], x, carry, cfg_mul2[s]);
      // Generate and propagate of the 2-bit add, subtract uses inverted B
      sub = cfg_op[s] == OP_SUB || (cfg_op[s] == OP_ADDSUB && !x[0]);
      bb = sub ? ~b : b;
      gsum = {1'b0, a} + {1'b0, bb};
      next_st.gen[s] = ripple & gsum[2];
      next_st.prop[s] = ripple & (gsum[1:0] == 2'h3);
      if (ripple) begin
        if (cfg_fast_carry[s] && cfg_op[s] <= OP_ADDSUB) begin
          carry = gsum[2] | ((gsum[1:0] == 2'h3) & carry);
        end else begin
          carry = r.co;
        end
        next_st.f[s] = r.f;
      end else begin
        // Logic, ROM and RAM read all come from the tables
        next_st.f[s] = lut_f[s];
      end
      if (cfg_direct[s]) begin
        dq = m_in[s];
      end else if (ripple) begin
        dq = r.qn;
      end else begin
        dq = lut_f[s];
      end
      setval = cfg_lsr_set[p] ? Q_SET : Q_RESET;
      // Async form acts on every system clock, ahead of enable and edge
      if (local_set_reset[p] && cfg_lsr_async[p]) begin
        next_st.q[s] = setval;
      end else if (tick[s] && !(ram_slice && s == RAM_CTRL_SLICE)) begin
        if (local_set_reset[p]) begin
          next_st.q[s] = setval;
        end else if (ce[p]) begin
          next_st.q[s] = dq;
        end
      end
    end
    next_st.cout = carry;
    if (ram_we) begin
      for (int j = 0; j < RAM_WIDTH; j++) begin
        next_st.lut[j][waddr] = m_in[j/2][j%2];
      end
    end
    // Preload wins over a user write in the same cycle
    if (cfg_load) begin
      next_st.lut[cfg_lut] = cfg_table;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st.lut <= {NUM_LUTS{LUT_RESET}};
      st.q <= {NUM_SLICES{Q_RESET}};
      st.f <= {NUM_SLICES{F_RESET}};
      st.gen <= '0;
      st.prop <= '0;
      st.cout <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs are registered copies, one system clock behind the inputs
  assign f_out = st.f;
  assign q_out = st.q;
  assign carry_gen = st.gen;
  assign carry_prop = st.prop;
  assign carry_chain_out = st.cout;

endmodule : logic_slice_group

// ---- hw/slice_group_pkg.sv ----
// Shared constants and types for the logic slice group
package slice_group_pkg;
  localparam int NUM_SLICES = 4;
  localparam int NUM_PAIRS = 2;
  localparam int NUM_LUTS = 8;
  localparam int LUT_BITS = 16;
  localparam int LUT_IN = 4;
  localparam int RAM_WIDTH = 4;
  localparam int RAM_STORE_SLICES = 2;
  localparam int RAM_CTRL_SLICE = 2;
  // Slice modes, two bits per slice
  localparam logic [1:0] MODE_LOGIC = 2'h0;
  localparam logic [1:0] MODE_RIPPLE = 2'h1;
  localparam logic [1:0] MODE_ROM = 2'h2;
  // Ripple functions, four bits per slice
  localparam logic [3:0] OP_ADD = 4'h0;
  localparam logic [3:0] OP_SUB = 4'h1;
  localparam logic [3:0] OP_ADDSUB = 4'h2;
  localparam logic [3:0] OP_CNT_UP = 4'h3;
  localparam logic [3:0] OP_CNT_DN = 4'h4;
  localparam logic [3:0] OP_CNT_UD = 4'h5;
  localparam logic [3:0] OP_CNT_LOAD = 4'h6;
  localparam logic [3:0] OP_CMP = 4'h7;
  localparam logic [3:0] OP_CNT_GE = 4'h8;
  localparam logic [3:0] OP_CNT_LE = 4'h9;
  localparam logic [3:0] OP_MULT_CELL = 4'hA;
  localparam logic [3:0] OP_SER_DIV = 4'hB;
  localparam logic [3:0] OP_SER_MUL = 4'hC;
  // Lookup input positions within one group of four
  localparam int IN_A = 0;
  localparam int IN_B = 1;
  localparam int IN_C = 2;
  localparam int IN_D = 3;
  // Reset and set values
  localparam logic [1:0] Q_RESET = 2'h0;
  localparam logic [1:0] Q_SET = 2'h3;
  localparam logic [1:0] F_RESET = 2'h0;
  localparam logic [LUT_BITS-1:0] LUT_RESET = 16'h0000;
  typedef logic [1:0] pair_bits_t;
endpackage : slice_group_pkg

// ---- hw/lut_pair.sv ----
// Two four-input lookup tables with the five-input merge
`timescale 1ns/1ns
module lut_pair
  import slice_group_pkg::*;
(
  // Programmed tables
  input wire logic [LUT_BITS-1:0] table0,
  input wire logic [LUT_BITS-1:0] table1,
  // Lookup inputs
  input wire logic [LUT_IN-1:0] in0,
  input wire logic [LUT_IN-1:0] in1,
  input wire logic sel,
  input wire logic lut5_en,
  // Lookup results
  output logic f0,
  output logic f1
);
  always_comb begin
    f0 = table0[in0];
    if (lut5_en) begin
      f0 = sel ? table1[in0] : table0[in0];
    end
    f1 = table1[in1];
  end
endmodule : lut_pair

// ---- hw/edge_sync.sv ----
// Three-stage synchroniser with edge pulses for a fabric slice clock
`timescale 1ns/1ns
module edge_sync (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Level from outside the domain
  input wire logic pin,
  // Edge pulses, one cycle each
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic [2:0] stage;
    logic level;
  } sync_state_t;
  sync_state_t st;
  sync_state_t next_st;
  logic agree;
  // Stage 0 feeds stage 1 only
  assign agree = st.stage[1] == st.stage[2];
  always_comb begin
    next_st = st;
    next_st.stage = {st.stage[1:0], pin};
    if (agree) begin
      next_st.level = st.stage[2];
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign rise = agree & st.stage[2] & ~st.level;
  assign fall = agree & ~st.stage[2] & st.level;
endmodule : edge_sync

// ---- bench/fabric_clk_model.sv ----
// Fabric-side model that makes one slice clock period per request
`timescale 1ns/1ns
module fabric_clk_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Requests in, slice clocks out
  input wire logic [1:0] req,
  output logic [1:0] slice_clk
);
  // Clock stands low between periods, as fabric clocks do when gated
  logic [1:0][3:0] left;
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      left <= '0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (left[p] != 4'h0) begin
          left[p] <= left[p] - 4'h1;
        end else if (req[p]) begin
          left[p] <= 4'h8;
        end
      end
    end
  end
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      slice_clk[p] = left[p] > 4'h4;
    end
  end
endmodule : fabric_clk_model

// ---- bench/slice_group_checker.sv ----
// Port-level assertions for the logic slice group
`timescale 1ns/1ns
module slice_group_checker
  import slice_group_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Configuration
  input wire logic cfg_load,
  input wire logic [2:0] cfg_lut,
  input wire logic [LUT_BITS-1:0] cfg_table,
  input wire logic [NUM_SLICES-1:0][1:0] cfg_mode,
  input wire logic [NUM_SLICES-1:0][3:0] cfg_op,
  input wire logic [NUM_SLICES-1:0] cfg_lut5,
  input wire logic [NUM_SLICES-1:0] cfg_direct,
  input wire logic [NUM_PAIRS-1:0] cfg_clk_sel,
  input wire logic [NUM_PAIRS-1:0] cfg_lsr_async,
  input wire logic [NUM_PAIRS-1:0] cfg_lsr_set,
  input wire logic cfg_ram_en,
  // Fabric inputs
  input wire logic [NUM_SLICES-1:0][1:0][LUT_IN-1:0] lut_in,
  input wire logic [NUM_SLICES-1:0] sel_in,
  input wire logic carry_chain_in,
  input wire logic [NUM_PAIRS-1:0] ce,
  input wire logic [NUM_PAIRS-1:0] local_set_reset,
  // Fabric outputs
  input wire logic [NUM_SLICES-1:0][1:0] f_out,
  input wire logic [NUM_SLICES-1:0][1:0] q_out,
  input wire logic [NUM_SLICES-1:0] carry_gen,
  input wire logic [NUM_SLICES-1:0] carry_prop
);
  // Only slice 3 tables are shadowed, RAM writes never reach them
  logic [LUT_BITS-1:0] tab6, tab7;
  logic run, lg3, look0, look1, rip0, nrip0, add0, isc0, cnt0;
  logic [1:0] a0, b0, sum0, cmp0;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      run <= 1'h0;
      tab6 <= LUT_RESET;
      tab7 <= LUT_RESET;
    end else begin
      run <= 1'h1;
      if (cfg_load && cfg_lut == 3'h6) tab6 <= cfg_table;
      if (cfg_load && cfg_lut == 3'h7) tab7 <= cfg_table;
    end
  end
  assign lg3 = !cfg_mode[3][0];
  assign look1 = tab7[lut_in[3][1]];
  assign look0 = (cfg_lut5[3] && sel_in[3]) ? tab7[lut_in[3][0]] : tab6[lut_in[3][0]];
  assign a0 = {lut_in[0][1][IN_A], lut_in[0][0][IN_A]};
  assign b0 = {lut_in[0][1][IN_B], lut_in[0][0][IN_B]};
  assign rip0 = cfg_mode[0] == MODE_RIPPLE && !cfg_ram_en;
  assign nrip0 = cfg_mode[0] != MODE_RIPPLE;
  assign add0 = rip0 && cfg_op[0] == OP_ADD;
  assign isc0 = rip0 && cfg_op[0] == OP_CMP;
  assign sum0 = a0 + b0 + {1'h0, carry_chain_in};
  assign cmp0 = {a0 != b0, lut_in[0][0][IN_C] ? a0 <= b0 : a0 >= b0};
  assign cnt0 = rip0 && cfg_op[0] == OP_CNT_UP && ce[0] && carry_chain_in
    && !local_set_reset[0] && !cfg_direct[0] && !cfg_clk_sel[0];
  AST_LUT4: assert property (run && $past(lg3) |-> f_out[3][1] == $past(look1))
    else $error("slice 3 lookup output wrong");
  AST_LUT5: assert property (run && $past(lg3) |-> f_out[3][0] == $past(look0))
    else $error("slice 3 merged lookup output wrong");
  AST_ADD: assert property (run && $past(add0) |-> f_out[0] == $past(sum0))
    else $error("slice 0 sum wrong");
  AST_CMP: assert property (run && $past(isc0) |-> f_out[0] == $past(cmp0))
    else $error("slice 0 compare wrong");
  AST_CNT_UP: assert property (cnt0 [*3] |=> q_out[0] == $past(q_out[0]) + 2'h1)
    else $error("slice 0 counter did not step up");
  AST_LSR_SET: assert property ((run && local_set_reset[1] && cfg_lsr_set[1]
    && (cfg_lsr_async[1] || !cfg_clk_sel[1])) [*2] |=> q_out[3] == Q_SET)
    else $error("slice 3 register not set");
  AST_CE_HOLD: assert property ((run && !ce[1] && !local_set_reset[1]) [*3]
    |=> $stable(q_out[3]))
    else $error("slice 3 register moved without enable");
  AST_NO_CARRY: assert property (run && $past(nrip0) |-> !carry_gen[0] && !carry_prop[0])
    else $error("carry terms active outside ripple");
endmodule : slice_group_checker

bind logic_slice_group slice_group_checker chk_i (.*);

// ---- bench/tb_logic_slice_group.sv ----
// Self-checking bench for the logic slice group
`timescale 1ns/1ns
module tb_logic_slice_group
  import slice_group_pkg::*;
;
  logic clk_sys = 1'h0, rst_b = 1'h0, cfg_load = 1'h0, cfg_ram_en = 1'h0, cfg_ram_pdp = 1'h0;
  logic carry_chain_in = 1'h0, carry_chain_out;
  logic [2:0] cfg_lut = 3'h0;
  logic [LUT_BITS-1:0] cfg_table = 16'h0000;
  logic [NUM_SLICES-1:0][1:0] cfg_mode = '0, m_in = '0, f_out, q_out;
  logic [NUM_SLICES-1:0][3:0] cfg_op = '0;
  logic [NUM_SLICES-1:0] cfg_lut5 = '0, cfg_direct = '0, cfg_fast_carry = '0, cfg_mul2 = '0;
  logic [NUM_SLICES-1:0] cfg_neg_edge = '0, sel_in = '0, carry_gen, carry_prop;
  logic [NUM_PAIRS-1:0] cfg_clk_sel = '0, cfg_lsr_async = '0, cfg_lsr_set = '0;
  logic [NUM_PAIRS-1:0] ce = '0, local_set_reset = '0, req = '0, slice_clk;
  logic [NUM_SLICES-1:0][1:0][LUT_IN-1:0] lut_in = '0;
  int fail_count = 0, n_tests = 0, cycles = 0;
  always #5 clk_sys = ~clk_sys;
  logic_slice_group uut (.*);
  fabric_clk_model fab (.clk_sys(clk_sys), .rst_b(rst_b), .req(req), .slice_clk(slice_clk));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  // Let one capture edge pass, then sample away from it
  task automatic look;
    @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : look
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic load(input logic [2:0] idx, input logic [15:0] tbl);
    cyc(1);
    cfg_load <= 1'h1;
    cfg_lut <= idx;
    cfg_table <= tbl;
    cyc(1);
    cfg_load <= 1'h0;
  endtask : load
  task automatic pulse;
    req[1] <= 1'h1;
    cyc(1);
    req[1] <= 1'h0;
  endtask : pulse
  task automatic t_sclk;
    cyc(1);
    cfg_direct[3] <= 1'h1;
    cfg_clk_sel[1] <= 1'h1;
    cfg_neg_edge[3] <= 1'h1;
    ce[1] <= 1'h1;
    m_in[3] <= 2'h2;
    cyc(10);
    pulse();
    cyc(6);
    @(negedge clk_sys);
    chk(q_out[3], 2'h0);
    cyc(8);
    @(negedge clk_sys);
    chk(q_out[3], 2'h2);
    cyc(1);
    cfg_neg_edge[3] <= 1'h0;
    m_in[3] <= 2'h1;
    pulse();
    cyc(8);
    @(negedge clk_sys);
    chk(q_out[3], 2'h1);
    // No slice clock edges here, so only the asynchronous path can act
    for (int v = 0; v < 2; v++) begin
      cyc(1);
      cfg_lsr_async[1] <= 1'h1;
      cfg_lsr_set[1] <= v[0];
      local_set_reset[1] <= 1'h1;
      cyc(3);
      local_set_reset[1] <= 1'h0;
      look();
      chk(q_out[3], v ? Q_SET : Q_RESET);
    end
    cyc(1);
    cfg_clk_sel[1] <= 1'h0;
    cfg_lsr_async[1] <= 1'h0;
  endtask : t_sclk
  task automatic t_logic;
    logic [15:0] t6 = 16'h6A93, t7 = 16'hC35E;
    load(3'h6, t6);
    load(3'h7, t7);
    for (int m = 0; m < 2; m++) begin
      for (int n = 0; n < 16; n++) begin
        cyc(1);
        cfg_mode[3] <= m ? MODE_ROM : MODE_LOGIC;
        cfg_lut5[3] <= m[0];
        sel_in[3] <= n[0];
        lut_in[3][0] <= n[3:0];
        lut_in[3][1] <= 4'(15 - n);
        look();
        chk(f_out[3][0], (m == 1 && n[0]) ? t7[n] : t6[n]);
        chk(f_out[3][1], t7[15 - n]);
      end
    end
  endtask : t_logic
  task automatic t_ripple;
    logic [3:0] ops [4] = '{OP_ADD, OP_SUB, OP_ADDSUB, OP_CMP};
    logic [1:0] a, b, bb, e;
    logic [2:0] g, w;
    logic k, c;
    // Upper half of each add, subtract and add-or-subtract sweep repeats it on the fast carry path
    for (int o = 0; o < 4; o++) begin
      for (int v = 0; v < 64; v++) begin
        a = v[1:0];
        b = v[3:2];
        k = v[4];
        bb = (o == 1 || (o == 2 && !k)) ? ~b : b;
        g = {1'h0, a} + {1'h0, bb};
        w = g + {2'h0, k};
        e = (o == 3) ? {a != b, k ? a <= b : a >= b} : w[1:0];
        c = (o == 3) ? (k ? a <= b : a > b) : w[2];
        cyc(1);
        cfg_mode[0] <= MODE_RIPPLE;
        cfg_op[0] <= ops[o];
        cfg_fast_carry[0] <= v[5];
        carry_chain_in <= k;
        lut_in[0][0] <= {1'h0, k, b[0], a[0]};
        lut_in[0][1] <= {2'h0, b[1], a[1]};
        look();
        chk(f_out[0], e);
        chk(carry_chain_out, c);
        chk(carry_gen[0], g[2]);
        chk(carry_prop[0], g[1:0] == 2'h3);
      end
    end
  endtask : t_ripple
  // Preload, counter compare, divide step, then every multiplier cell input
  task automatic t_ops;
    logic [1:0] m, n;
    cyc(1);
    cfg_mode[0] <= MODE_RIPPLE;
    cfg_op[0] <= OP_CNT_LOAD;
    carry_chain_in <= 1'h1;
    ce[0] <= 1'h1;
    lut_in[0] <= {4'h2, 4'h8};
    cyc(1);
    lut_in[0][0] <= 4'h0;
    look();
    chk(q_out[0], 2'h1);
    chk(f_out[0], 2'h2);
    cyc(1);
    cfg_op[0] <= OP_CNT_GE;
    lut_in[0][0] <= 4'h4;
    look();
    chk(q_out[0], 2'h1);
    look();
    look();
    chk(f_out[0], 2'h1);
    look();
    chk(f_out[0], 2'h3);
    cyc(1);
    cfg_op[0] <= OP_SER_DIV;
    lut_in[0][0] <= 4'h6;
    look();
    chk(q_out[0], 2'h0);
    chk(f_out[0], 2'h1);
    for (int v = 0; v < 512; v++) begin
      cyc(1);
      cfg_op[0] <= OP_MULT_CELL;
      carry_chain_in <= v[8];
      lut_in[0][0] <= v[3:0];
      lut_in[0][1] <= v[7:4];
      look();
      m = {1'h0, v[0] & v[5]} + {1'h0, v[4] & v[1]} + {1'h0, v[8]};
      n = {1'h0, v[2] & v[7]} + {1'h0, v[6] & v[3]} + {1'h0, m[1]};
      chk(f_out[0], {n[0], m[0]});
      chk(carry_chain_out, n[1]);
    end
  endtask : t_ops
  task automatic t_count;
    logic [1:0] q;
    for (int d = 0; d < 2; d++) begin
      cyc(1);
      cfg_op[0] <= d ? OP_CNT_DN : OP_CNT_UP;
      carry_chain_in <= 1'h1;
      ce[0] <= 1'h1;
      cyc(3);
      @(negedge clk_sys);
      q = q_out[0];
      repeat (3) begin
        @(negedge clk_sys);
        q = d ? q - 2'h1 : q + 2'h1;
        chk(q_out[0], q);
      end
    end
    cyc(1);
    ce[0] <= 1'h0;
    cfg_mode[0] <= MODE_LOGIC;
  endtask : t_count
  task automatic t_ram;
    logic [3:0] ad [3] = '{4'h5, 4'hA, 4'h3};
    logic [3:0] wd [3] = '{4'h9, 4'h6, 4'hF};
    for (int i = 0; i < 4; i++) load(3'(i), 16'hFFFF);
    cyc(1);
    cfg_ram_en <= 1'h1;
    cfg_ram_pdp <= 1'h1;
    m_in[2][0] <= 1'h1;
    for (int i = 0; i < 2; i++) begin
      lut_in[2][0] <= ad[i];
      m_in[0] <= wd[i][1:0];
      m_in[1] <= wd[i][3:2];
      cyc(1);
    end
    m_in[2][0] <= 1'h0;
    for (int i = 0; i < 3; i++) begin
      lut_in[0] <= {2{ad[i]}};
      lut_in[1] <= {2{ad[i]}};
      cyc(1);
      look();
      chk({f_out[1], f_out[0]}, wd[i]);
      cyc(1);
    end
    // Single port reads at the write address, not at the own inputs
    cfg_ram_pdp <= 1'h0;
    lut_in[2][0] <= ad[0];
    look();
    chk({f_out[1], f_out[0]}, wd[0]);
  endtask : t_ram
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  // Whole sequence needs under two thousand cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      close_out();
    end
  end
  initial begin
    cyc(6);
    rst_b <= 1'h1;
    cyc(4);
    t_sclk();
    t_logic();
    t_ripple();
    t_ops();
    t_count();
    t_ram();
    close_out();
  end
endmodule : tb_logic_slice_group
